/* File: pkg/acs_map.svh */
// Purpose: Offsets, field positions and reset values of the clock selectors
// Assumes: 8-bit registers on the byte-wide control port
// Notes:   Definitions only
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define ACS_OFS_ROOT_SRC   8'h0d
`define ACS_OFS_DAC_OVS    8'h0e
`define ACS_OFS_PUMP       8'h0f
`define ACS_OFS_DSP_DAC    8'h10
`define ACS_OFS_PUMP_OVS   8'h11
`define ACS_OFS_PLL_REF    8'h12
`define ACS_OFS_FIRST      8'h0d
// ****************************************
// Field positions (low bit of 3-bit field)
// ****************************************
`define ACS_FLD_HI         4
`define ACS_FLD_LO         0
`define ACS_FLD_W          3
// ****************************************
// Reset values
// ****************************************
`define ACS_RST_REG        8'h00
// ****************************************
// Timing counts
// ****************************************
`define ACS_SYNC_STAGES    3
`endif

/* File: pkg/acs_pkg.sv */
// Purpose: Types shared by the clock source selector
// Assumes: acs_map.svh holds the numbers
// Notes:   Codes follow the selector encodings
package acs_pkg;
  // Divider source codes for the DAC and DSP selectors
  typedef enum logic [2:0] {
    ACS_DS_MASTER = 3'h0,
    ACS_DS_PLL    = 3'h1,
    ACS_DS_OSC    = 3'h2,
    ACS_DS_MCLK   = 3'h3,
    ACS_DS_SCLK   = 3'h4,
    ACS_DS_GPIN   = 3'h5
  } acs_div_src_t;

  // General pin codes, shared by all pin selectors
  typedef enum logic [2:0] {
    ACS_PIN_ZERO = 3'h3,
    ACS_PIN_TWO  = 3'h5
  } acs_pin_t;

  // Raw clock levels entering the block
  typedef struct packed {
    logic pll;
    logic osc;
    logic mclk;
    logic sclk;
    logic gp0;
    logic gp2;
    logic mstr_ok;
  } acs_src_t;

  // Control port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acs_req_t;

  // Selected clocks toward the dividers
  typedef struct packed {
    logic dsp;
    logic dac;
    logic ovs;
    logic pump;
    logic pll_ref;
  } acs_clk_t;
endpackage : acs_pkg

/* File: design/acs_clock_select.sv */
// Purpose: Register-controlled source muxing for the internal clock dividers
// Assumes: Source clocks are far slower than sys_clk and are oversampled
// Notes:   Muted selections give a steady low level
// How it works
// - The DAC divider follows the source coded in bits 6-4 of 0x0e.
// - The oversampling divider follows the source coded in bits 2-0 of 0x0e.
// - The charge-pump divider uses the oversampling encoding from 0x0f.
// - The DSP pin source is pin 0 for code 011 and pin 2 for 101.
// - The DAC pin source is pin 0 for code 011 and pin 2 for 101.
// - The charge-pump pin source is pin 0 for 011 and pin 2 for 101.
// - The oversampling pin source is pin 0 for 011 and pin 2 for 101.
// - The PLL reference pin is pin 0 for code 011 and pin 2 for 101.
// - Every selector resets to zero, giving the auto master for the DAC.
// - The DSP divider source is coded like the DAC source selector.
// - The PLL reference source is chosen in 0x0d and auto mode overrides it.
`timescale 1ns/10ps
`include "acs_map.svh"
module acs_clock_select (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire acs_pkg::acs_src_t src_pins,
  input  wire logic             auto_clock_mode,
  input  wire acs_pkg::acs_req_t reg_req,
  output logic [7:0]            reg_rdata_q,
  output acs_pkg::acs_clk_t     div_clk_q
);
  import acs_pkg::*;

  localparam int NREG = 6;

  // ****************************************
  // Helper functions
  // ****************************************
  // Pin pick shared by all five pin selectors
  function automatic logic pin_pick(input logic [2:0] sel,
                                    input acs_src_t   s);
    logic r;
    r = 1'b0;
    case (sel)
      ACS_PIN_ZERO: r = s.gp0;
      ACS_PIN_TWO:  r = s.gp2;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction : pin_pick

  // Auto master prefers the PLL when mstr_ok is set, oscillator as fallback
  function automatic logic master_clk(input acs_src_t s);
    return s.mstr_ok ? s.pll : s.osc;
  endfunction : master_clk

  // DAC and DSP style selector; unknown codes mute
  function automatic logic div_mux(input logic [2:0] sel,
                                   input logic [2:0] pin_sel,
                                   input acs_src_t   s);
    logic r;
    r = 1'b0;
    case (sel)
      ACS_DS_MASTER: r = master_clk(s);
      ACS_DS_PLL:    r = s.pll;
      ACS_DS_OSC:    r = s.osc;
      ACS_DS_MCLK:   r = s.mclk;
      ACS_DS_SCLK:   r = s.sclk;
      ACS_DS_GPIN:   r = pin_pick(pin_sel, s);
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : div_mux

  // Oversampling and charge-pump selector; code 0 is the DAC clock
  function automatic logic ovs_mux(input logic [2:0] sel,
                                   input logic [2:0] pin_sel,
                                   input logic       dac,
                                   input acs_src_t   s);
    logic r;
    r = 1'b0;
    case (sel)
      3'h0:    r = dac;
      3'h6:    r = pin_pick(pin_sel, s);
      3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
               r = div_mux(sel - 3'h1, 3'h0, s);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : ovs_mux

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] regs_q [NREG];
  logic [7:0] regs_d [NREG];
  logic [7:0] rdata_d;
  logic [7:0] idx;

  // Index relative to the first selector; out-of-range is unmapped
  assign idx = reg_req.addr - `ACS_OFS_FIRST;

  // Write storage and read data; reserved bits are plain storage
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
    end
    rdata_d = reg_rdata_q;
    if (reg_req.wr && idx < 8'(NREG)) begin
      regs_d[idx[2:0]] = reg_req.wdata;
    end
    if (reg_req.rd) begin
      rdata_d = (idx < 8'(NREG)) ? regs_q[idx[2:0]] : 8'h00;
    end
  end

  // Synchronous reset clears every selector
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= `ACS_RST_REG;
      end
      reg_rdata_q <= `ACS_RST_REG;
    end else if (clk_en) begin
      regs_q      <= regs_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // Field views
  logic [2:0] root_ref_sel, dsp_sel, dac_sel, ovs_sel, pump_sel;
  logic [2:0] dsp_pin, dac_pin, pump_pin, ovs_pin, ref_pin;
  assign root_ref_sel = regs_q[0][`ACS_FLD_HI +: `ACS_FLD_W];
  assign dsp_sel      = regs_q[0][`ACS_FLD_LO +: `ACS_FLD_W];
  assign dac_sel      = regs_q[1][`ACS_FLD_HI +: `ACS_FLD_W];
  assign ovs_sel      = regs_q[1][`ACS_FLD_LO +: `ACS_FLD_W];
  assign pump_sel     = regs_q[2][`ACS_FLD_LO +: `ACS_FLD_W];
  assign dsp_pin      = regs_q[3][`ACS_FLD_HI +: `ACS_FLD_W];
  assign dac_pin      = regs_q[3][`ACS_FLD_LO +: `ACS_FLD_W];
  assign pump_pin     = regs_q[4][`ACS_FLD_HI +: `ACS_FLD_W];
  assign ovs_pin      = regs_q[4][`ACS_FLD_LO +: `ACS_FLD_W];
  assign ref_pin      = regs_q[5][`ACS_FLD_LO +: `ACS_FLD_W];

  // ****************************************
  // Source synchronisers
  // ****************************************
  // Three stages; a level is accepted once stages two and three agree,
  // which rejects single-sample glitches at the cost of latency
  acs_src_t s1_q, s2_q, s3_q, filt_q, filt_d;

  always_comb begin
    filt_d = filt_q;
    for (int b = 0; b < $bits(acs_src_t); b++) begin
      if (s2_q[b] == s3_q[b]) begin
        filt_d[b] = s3_q[b];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else if (clk_en) begin
      s1_q   <= src_pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // ****************************************
  // Clock selection
  // ****************************************
  acs_clk_t clk_d;
  logic     dac_now;

  // DAC clock is computed first since two other muxes may follow it
  assign dac_now = div_mux(dac_sel, dac_pin, filt_q);

  always_comb begin
    clk_d.dac = dac_now;
    clk_d.dsp = div_mux(dsp_sel, dsp_pin, filt_q);
    clk_d.ovs  = ovs_mux(ovs_sel, ovs_pin, dac_now, filt_q);
    clk_d.pump = ovs_mux(pump_sel, pump_pin, dac_now, filt_q);
    // Auto mode forces the MCLK pin as reference
    if (auto_clock_mode) begin
      clk_d.pll_ref = filt_q.mclk;
    end else begin
      case (root_ref_sel)
        3'h0:    clk_d.pll_ref = filt_q.mclk;
        3'h1:    clk_d.pll_ref = filt_q.sclk;
        3'h2:    clk_d.pll_ref = filt_q.osc;
        3'h3:    clk_d.pll_ref = pin_pick(ref_pin, filt_q);
        default: clk_d.pll_ref = 1'b0;
      endcase
    end
  end

  // Registered outputs, held low through reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_clk_q <= '0;
    end else if (clk_en) begin
      div_clk_q <= clk_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_reset_zero_regs: assert property ($rose(rst_n) |->
      regs_q[1] == 8'h00 && regs_q[3] == 8'h00 && regs_q[5] == 8'h00)
    else $error("selector not zero after reset");
  a_dac_mute_low: assert property (clk_en && dac_sel > 3'h5
      |=> !div_clk_q.dac)
    else $error("muted DAC clock not low");
  a_dac_pll_path: assert property (clk_en && dac_sel == 3'h1
      |=> div_clk_q.dac == $past(filt_q.pll))
    else $error("DAC clock not following PLL");
  a_ovs_follow_dac: assert property (clk_en && ovs_sel == 3'h0
      |=> div_clk_q.ovs == div_clk_q.dac)
    else $error("oversampling clock not tracking DAC clock");
  a_pump_mute_low: assert property (clk_en && pump_sel == 3'h7
      |=> !div_clk_q.pump)
    else $error("muted pump clock not low");
  a_dsp_pin_two: assert property (clk_en && dsp_sel == 3'h5
      && dsp_pin == 3'h5 |=> div_clk_q.dsp == $past(filt_q.gp2))
    else $error("DSP clock not from pin two");
  a_dac_pin_na: assert property (clk_en && dac_sel == 3'h5
      && dac_pin == 3'h4 |=> !div_clk_q.dac)
    else $error("unusable DAC pin not muted");
  a_pump_pin_zero: assert property (clk_en && pump_sel == 3'h6
      && pump_pin == 3'h3 |=> div_clk_q.pump == $past(filt_q.gp0))
    else $error("pump clock not from pin zero");
  a_ovs_pin_rsvd: assert property (clk_en && ovs_sel == 3'h6
      && ovs_pin == 3'h2 |=> !div_clk_q.ovs)
    else $error("reserved oversampling pin not muted");
  a_ref_pin_zero: assert property (clk_en && !auto_clock_mode
      && root_ref_sel == 3'h3 && ref_pin == 3'h3
      |=> div_clk_q.pll_ref == $past(filt_q.gp0))
    else $error("reference not from pin zero");
  a_ref_auto_mode: assert property (clk_en && auto_clock_mode
      |=> div_clk_q.pll_ref == $past(filt_q.mclk))
    else $error("auto mode not overriding reference");
  a_freeze_hold: assert property (!clk_en |=> $stable(div_clk_q))
    else $error("outputs moved while frozen");

  c_dac_from_pin: cover property (dac_sel == 3'h5 && dac_pin == 3'h3
      ##1 div_clk_q.dac);
  c_ovs_toggle: cover property (ovs_sel == 3'h2 && div_clk_q.ovs
      ##1 !div_clk_q.ovs);
  c_ref_auto: cover property (auto_clock_mode && root_ref_sel == 3'h2);
endmodule : acs_clock_select

/* File: testbench/acs_clock_select_tb_top.sv */
// Purpose: Self-checking bench for the clock source selector
// Assumes: Selected levels settle within 8 cycles of a pin change
// Notes:   Inputs change on the falling edge only
`timescale 1ns/10ps
`include "acs_map.svh"
module acs_clock_select_tb_top;
  import acs_pkg::*;
  logic       sys_clk;
  logic       rst_n;
  logic       clk_en;
  acs_src_t   src_pins;
  logic       auto_clock_mode;
  acs_req_t   reg_req;
  logic [7:0] reg_rdata_q;
  acs_clk_t   div_clk_q;
  int         err_count;
  int         checks;

  acs_clock_select dut_u (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .src_pins        (src_pins),
    .auto_clock_mode (auto_clock_mode),
    .reg_req         (reg_req),
    .reg_rdata_q     (reg_rdata_q),
    .div_clk_q       (div_clk_q)
  );

  // ****************************************
  // Clock, helpers and verdict
  // ****************************************
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d of %0d compares", err_count, checks);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask : do_reset

  // Strobes last exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    check(reg_rdata_q, exp);
  endtask : rd

  // Mask over {pll,osc,mclk,sclk,gp0,gp2}; mode 0 DAC/DSP, 1 ovs/pump,
  // 2 PLL reference, 3 pin selector. DAC field is held at osc for mode 1.
  function automatic logic [5:0] pick(input logic [2:0] c, input int mode,
                                      input logic [5:0] gpm);
    logic [2:0] d;
    d = c;
    if (mode == 3) return (c == 3'h3) ? 6'h02 : (c == 3'h5) ? 6'h01 : 6'h00;
    if (mode == 2) return (c == 3'h0) ? 6'h08 : (c == 3'h1) ? 6'h04 :
                          (c == 3'h2) ? 6'h10 : (c == 3'h3) ? gpm : 6'h00;
    if (mode == 1) begin
      if (c == 3'h0) return 6'h10;
      d = c - 3'h1;
    end
    case (d)
      3'h0, 3'h1: return 6'h20;
      3'h2:       return 6'h10;
      3'h3:       return 6'h08;
      3'h4:       return 6'h04;
      3'h5:       return gpm;
      default:    return 6'h00;
    endcase
  endfunction : pick

  // Every code against every lone active source
  task automatic sweep(input logic [7:0] a, input logic [7:0] base,
                       input int sh, input int ob, input int mode,
                       input logic [5:0] gpm);
    logic [5:0] one;
    for (int c = 0; c < 8; c++) begin
      wr(a, base | 8'(c << sh));
      for (int i = 0; i < 6; i++) begin
        one = 6'h20 >> i;
        src_pins = acs_src_t'({one, 1'b1});
        repeat (8) @(negedge sys_clk);
        check({7'h00, div_clk_q[ob]},
              {7'h00, |(one & pick(c[2:0], mode, gpm))});
      end
    end
  endtask : sweep

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    for (int i = 0; i < 6; i++) wr(`ACS_OFS_FIRST + 8'(i), 8'h5a ^ 8'(i));
    wr(8'h13, 8'hff);
    for (int i = 0; i < 6; i++) rd(`ACS_OFS_FIRST + 8'(i), 8'h5a ^ 8'(i));
    rd(8'h13, 8'h00);
    do_reset();
    for (int i = 0; i < 6; i++) rd(`ACS_OFS_FIRST + 8'(i), 8'h00);
  endtask : t_regs

  // Auto master falls back to osc; oversampling and pump follow DAC
  task automatic t_default();
    @(negedge sys_clk);
    src_pins = acs_src_t'(7'b0100000);
    repeat (8) @(negedge sys_clk);
    check({3'h0, div_clk_q}, 8'h1e);
  endtask : t_default

  task automatic t_auto();
    wr(`ACS_OFS_ROOT_SRC, 8'h20);
    src_pins = acs_src_t'(7'b0010001);
    auto_clock_mode = 1'b1;
    repeat (8) @(negedge sys_clk);
    check({7'h00, div_clk_q.pll_ref}, 8'h01);
    auto_clock_mode = 1'b0;
    repeat (8) @(negedge sys_clk);
    check({7'h00, div_clk_q.pll_ref}, 8'h00);
  endtask : t_auto

  // A write while frozen is lost
  task automatic t_freeze();
    @(negedge sys_clk);
    clk_en = 1'b0;
    wr(`ACS_OFS_PLL_REF, 8'h05);
    clk_en = 1'b1;
    rd(`ACS_OFS_PLL_REF, 8'h07);
  endtask : t_freeze

  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    err_count = 0;
    checks = 0;
    clk_en = 1'b1;
    auto_clock_mode = 1'b0;
    src_pins = '0;
    reg_req = '0;
    do_reset();
    t_regs();
    t_default();
    wr(`ACS_OFS_DSP_DAC, 8'h35);
    wr(`ACS_OFS_PUMP_OVS, 8'h53);
    wr(`ACS_OFS_PLL_REF, 8'h03);
    sweep(`ACS_OFS_DAC_OVS, 8'h00, 4, 3, 0, 6'h01);
    sweep(`ACS_OFS_ROOT_SRC, 8'h00, 0, 4, 0, 6'h02);
    sweep(`ACS_OFS_DAC_OVS, 8'h20, 0, 2, 1, 6'h02);
    sweep(`ACS_OFS_PUMP, 8'h00, 0, 1, 1, 6'h01);
    sweep(`ACS_OFS_ROOT_SRC, 8'h00, 4, 0, 2, 6'h02);
    wr(`ACS_OFS_ROOT_SRC, 8'h35);
    wr(`ACS_OFS_DAC_OVS, 8'h56);
    wr(`ACS_OFS_PUMP, 8'h06);
    sweep(`ACS_OFS_DSP_DAC, 8'h00, 4, 4, 3, 6'h00);
    sweep(`ACS_OFS_DSP_DAC, 8'h00, 0, 3, 3, 6'h00);
    sweep(`ACS_OFS_PUMP_OVS, 8'h00, 4, 1, 3, 6'h00);
    sweep(`ACS_OFS_PUMP_OVS, 8'h00, 0, 2, 3, 6'h00);
    sweep(`ACS_OFS_PLL_REF, 8'h00, 0, 0, 3, 6'h00);
    t_freeze();
    t_auto();
    results();
  end
endmodule : acs_clock_select_tb_top
